// *** shared/fbi_defines.svh ***
`ifndef FBI_DEFINES_SVH
`define FBI_DEFINES_SVH

// Reference clock period in picoseconds.
`define FBI_CLK_PERIOD_PS 5000
// Shortest strobe pulse that is honoured, in picoseconds.
`define FBI_GLITCH_PS 5000
// Glitch filter length in cycles; a least time, so it rounds up.
`define FBI_GLITCH_CYC ((`FBI_GLITCH_PS + `FBI_CLK_PERIOD_PS - 1) / `FBI_CLK_PERIOD_PS)
// Default idle cycles before automatic low power.
`define FBI_IDLE_CYC 64
// Internal register selects, as word addresses.
`define FBI_ADDR_MAKER 19'h0_0000
`define FBI_ADDR_PART 19'h0_0001
`define FBI_ADDR_BURST 19'h0_0005
// Reset value of the burst configuration register.
`define FBI_BURST_RST 16'hFFFF
// Page size in words and the width of the in-page index.
`define FBI_PAGE_WORDS 4
`define FBI_PAGE_BITS 2

`endif

// *** shared/fbi_pkg.sv ***
package fbi_pkg;

  // What an asynchronous read returns.
  typedef enum logic [1:0]
  {
    FBI_READ_ARRAY,
    FBI_READ_SIGNATURE,
    FBI_READ_STATUS,
    FBI_READ_QUERY
  } fbi_read_state_t;

  // Power state of the interface.
  typedef enum logic [1:0]
  {
    FBI_PWR_ACTIVE,
    FBI_PWR_STANDBY,
    FBI_PWR_AUTO_LOW,
    FBI_PWR_DOWN
  } fbi_power_t;

endpackage

// *** hdl/fbi_glitch_filter.sv ***
`include "fbi_defines.svh"

// Passes a strobe level on only once it has held for LEN cycles.
module fbi_glitch_filter
  import fbi_pkg::*;
#(
  parameter int LEN = `FBI_GLITCH_CYC
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      filt
);

  // Cycles the raw level has differed from the filtered one.
  logic [7:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Short pulses never reach the output; strobes idle high.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= 8'h00;
      filt    <= 1'b1;
    end
    else if (raw == filt)
    begin
      cnt_reg <= 8'h00;
    end
    else if (cnt_reg >= 8'(LEN - 1))
    begin
      cnt_reg <= 8'h00;
      filt    <= raw;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

endmodule

// *** hdl/fbi_flash_bus.sv ***
// What this block does
// RULE_01: After reset only asynchronous reads and writes.
// RULE_02: Register reads always use asynchronous timing.
// RULE_03: Ignore short pulses on select and strobe.
// RULE_04: Select and enable low, strobe high: drive data.
// RULE_05: Read returns array or selected internal register.
// RULE_06: Address latch captures on latch rising edge.
// RULE_07: Latch is transparent while its enable is low.
// RULE_08: Pages hold four words, indexed by low bits.
// RULE_09: First page access slow, same page fast.
// RULE_10: Host never mixes latched addressing with pages.
// RULE_11: Host starts writes with select, strobe, latch low.
// RULE_12: Write address captured on first rising strobe.
// RULE_13: Write data captured on first rising strobe.
// RULE_14: Host keeps output enable high during writes.
// RULE_15: Burst clock ignored during asynchronous writes.
// RULE_16: Latched write captures on first rising edge.
// RULE_17: Float data when enable high or disable low.
// RULE_18: Select high and controller idle: standby, float.
// RULE_19: Idle bus during reads enters reduced current.
// RULE_20: Reset/power-down low: power-down, data floats.
// RULE_21: Power-down blocks writes, clears status register.
// RULE_22: Status read drives upper 24 lines low.
// RULE_23: Idle interval is a parameter, cleared by activity.
`include "fbi_defines.svh"

module fbi_flash_bus
  import fbi_pkg::*;
#(
  parameter int AW        = 19,
  parameter int DW        = 32,
  parameter int IDLE_CYC  = `FBI_IDLE_CYC,
  parameter int SLOW_CYC  = 14,
  parameter int FAST_CYC  = 5,
  parameter logic [DW-1:0] MAKER_CODE = 32'h0000_00A5, // Arbitrary value.
  parameter logic [DW-1:0] PART_CODE  = 32'h0000_5A5A  // Arbitrary value.
)
(
  input  wire logic          REF_CLK,
  input  wire logic          RST,
  input  wire logic          CHIP_ENABLE_N,
  input  wire logic          OUTPUT_ENABLE_N,
  input  wire logic          OUTPUT_DISABLE_N,
  input  wire logic          WRITE_ENABLE_N,
  input  wire logic          LATCH_ENABLE_N,
  input  wire logic          RESET_POWERDOWN_N,
  input  wire logic          BURST_CLK,
  input  wire logic [AW-1:0] ADDRESS_IN,
  input  wire logic [DW-1:0] DATA_IO_IN,
  output logic      [DW-1:0] DATA_IO_OUT,
  output logic               DATA_IO_OE,
  output logic      [AW-1:0] ARRAY_ADDR,
  output logic               ARRAY_RD,
  input  wire logic [DW-1:0] ARRAY_DATA,
  output logic      [AW-1:0] WR_ADDR,
  output logic      [DW-1:0] WR_DATA,
  output logic               WR_STROBE,
  input  wire logic [1:0]    READ_STATE,
  input  wire logic [7:0]    STATUS_IN,
  input  wire logic [DW-1:0] QUERY_DATA,
  input  wire logic          PE_BUSY,
  input  wire logic          BURST_CFG_WE,
  input  wire logic [15:0]   BURST_CFG_IN,
  output logic               SYNC_ALLOWED,
  output logic               CTRL_RESET,
  output logic [1:0]         POWER_STATE,
  output logic [7:0]         STATUS_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Filtered strobes and internal signals.

  logic             ce_f;          // Chip select after the glitch filter.
  logic             we_f;          // Write strobe after the glitch filter.
  logic             ce_d_reg;      // Last filtered chip select.
  logic             we_d_reg;      // Last filtered write strobe.
  logic             le_d_reg;      // Last latch enable.
  logic [AW-1:0]    lat_addr_reg;  // Address latch contents.
  logic [AW-1:0]    eff_addr;      // Address the core uses.
  logic             pd;            // Power-down held.
  logic             read_on;       // Read cycle qualifies.
  logic             cfg_done_reg;  // Burst configuration written.
  logic [15:0]      burst_cfg_reg; // Burst configuration register.
  logic [AW-1:0]    page_reg;      // Page tag held in the buffer.
  logic             page_ok_reg;   // Page tag is valid.
  logic [DW-1:0]    page_buf [`FBI_PAGE_WORDS];  // Page buffer words.
  logic [7:0]       wait_reg;      // Access time countdown.
  logic [15:0]      idle_reg;      // Idle counter for auto low power.
  logic [AW+4:0]    bus_snap_reg;  // Last sampled bus input vector.
  logic [DW-1:0]    rd_word;       // Selected read word.
  fbi_read_state_t  rstate;        // Current read state.
  logic             reg_read;      // Read targets an internal register.
  logic             page_hit;      // Address lies in buffered page.

  // Power-down follows the pin directly.
  assign pd = ~RESET_POWERDOWN_N; // RULE_20

  // The burst clock feeds nothing; asynchronous mode never samples it.
  logic unused_burst_clk;
  assign unused_burst_clk = BURST_CLK; // RULE_15

  // Chip select glitch filter.
  fbi_glitch_filter #(.LEN(`FBI_GLITCH_CYC)) u_ce_filt
  (
    .clk  (REF_CLK),
    .rst  (RST | pd),
    .raw  (CHIP_ENABLE_N),
    .filt (ce_f)
  ); // RULE_03

  // Write strobe glitch filter.
  fbi_glitch_filter #(.LEN(`FBI_GLITCH_CYC)) u_we_filt
  (
    .clk  (REF_CLK),
    .rst  (RST | pd),
    .raw  (WRITE_ENABLE_N),
    .filt (we_f)
  ); // RULE_03

  ////////////////////////////////////////////////////////////////////////////
  // Edge history of the strobes.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      ce_d_reg <= 1'b1;
      we_d_reg <= 1'b1;
      le_d_reg <= 1'b1;
    end
    else
    begin
      ce_d_reg <= ce_f;
      we_d_reg <= we_f;
      le_d_reg <= LATCH_ENABLE_N;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address latch: transparent while low, holds from its rising edge.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      lat_addr_reg <= '0;
    end
    else if (!LATCH_ENABLE_N)
    begin
      lat_addr_reg <= ADDRESS_IN; // RULE_07
    end
  end

  // A high latch enable freezes the captured address for the cycle.
  assign eff_addr = LATCH_ENABLE_N ? lat_addr_reg : ADDRESS_IN; // RULE_06

  // Returns true on the rising edge of the first strobe to rise.
  function automatic logic first_rise(input logic d_ce, input logic ce,
                                      input logic d_we, input logic we);
    first_rise = (!d_ce && !d_we) && (ce || we);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write capture into the command interface.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      WR_ADDR   <= '0;
      WR_DATA   <= '0;
      WR_STROBE <= 1'b0; // RULE_21
    end
    else if (first_rise(ce_d_reg, ce_f, we_d_reg, we_f))
    begin
      // The latch edge, if first, already froze eff_addr.
      WR_ADDR   <= eff_addr;   // RULE_12 RULE_16
      WR_DATA   <= DATA_IO_IN; // RULE_13
      WR_STROBE <= 1'b1;
    end
    else
    begin
      WR_STROBE <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst configuration; until written only asynchronous cycles run.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      cfg_done_reg  <= 1'b0;
      burst_cfg_reg <= `FBI_BURST_RST;
    end
    else if (BURST_CFG_WE)
    begin
      cfg_done_reg  <= 1'b1;
      burst_cfg_reg <= BURST_CFG_IN;
    end
  end

  // Synchronous modes are offered only after configuration.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      SYNC_ALLOWED <= 1'b0; // RULE_01
    end
    else
    begin
      SYNC_ALLOWED <= cfg_done_reg;
    end
  end

  // Controller reset and status mirror.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      CTRL_RESET <= 1'b1;
      STATUS_OUT <= 8'h00;
    end
    else
    begin
      CTRL_RESET <= pd;                          // RULE_21
      STATUS_OUT <= pd ? 8'h00 : STATUS_IN;      // RULE_21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path selection.
  assign rstate   = fbi_read_state_t'(READ_STATE);
  assign reg_read = (rstate != FBI_READ_ARRAY) ||
                    (eff_addr == `FBI_ADDR_BURST && rstate == FBI_READ_SIGNATURE);
  assign read_on  = !pd && !ce_f && !OUTPUT_ENABLE_N && OUTPUT_DISABLE_N && we_f; // RULE_04
  assign page_hit = page_ok_reg &&
                    (page_reg[AW-1:`FBI_PAGE_BITS] == eff_addr[AW-1:`FBI_PAGE_BITS]);

  // Word chosen by read state; registers bypass the page buffer.
  always_comb
  begin
    rd_word = '0;
    unique case (rstate)
      FBI_READ_ARRAY:
      begin
        rd_word = page_buf[eff_addr[`FBI_PAGE_BITS-1:0]]; // RULE_08
      end
      FBI_READ_SIGNATURE:
      begin
        if (eff_addr == `FBI_ADDR_MAKER)
          rd_word = MAKER_CODE;
        else if (eff_addr == `FBI_ADDR_PART)
          rd_word = PART_CODE;
        else if (eff_addr == `FBI_ADDR_BURST)
          rd_word = {16'h0000, burst_cfg_reg};
      end
      FBI_READ_STATUS:
      begin
        rd_word = {24'h00_0000, STATUS_IN}; // RULE_22
      end
      FBI_READ_QUERY:
      begin
        rd_word = QUERY_DATA;
      end
    endcase
  end // RULE_05 RULE_02

  ////////////////////////////////////////////////////////////////////////////
  // Page fetch: a miss waits slow time and fills; a hit waits fast time.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      page_ok_reg <= 1'b0;
      page_reg    <= '0;
      ARRAY_RD    <= 1'b0;
      ARRAY_ADDR  <= '0;
    end
    else if (read_on && rstate == FBI_READ_ARRAY && !page_hit)
    begin
      // Fill one word per cycle; tag becomes valid after the last.
      ARRAY_RD   <= 1'b1;
      // The first fetch uses word 0; later fetches step after each stored word.
      ARRAY_ADDR <= {eff_addr[AW-1:`FBI_PAGE_BITS],
                     ARRAY_RD ? ARRAY_ADDR[`FBI_PAGE_BITS-1:0] + 2'd1 : 2'd0};
      if (ARRAY_RD)
      begin
        page_buf[ARRAY_ADDR[`FBI_PAGE_BITS-1:0]] <= ARRAY_DATA;
        if (ARRAY_ADDR[`FBI_PAGE_BITS-1:0] == 2'd3)
        begin
          page_ok_reg <= 1'b1;
          page_reg    <= eff_addr; // RULE_09
        end
      end
    end
    else
    begin
      ARRAY_RD <= 1'b0;
      ARRAY_ADDR[`FBI_PAGE_BITS-1:0] <= 2'd0;
    end
  end

  // Access timer restarts on any address or selection change.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd || !read_on)
    begin
      wait_reg <= 8'(SLOW_CYC);
    end
    else if (bus_snap_reg[AW-1:0] != eff_addr)
    begin
      wait_reg <= (page_hit && !reg_read) ? 8'(FAST_CYC) : 8'(SLOW_CYC); // RULE_09
    end
    else if (wait_reg != 8'h00 && (page_hit || reg_read))
    begin
      wait_reg <= wait_reg - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data bus drive: float unless a read is selected and ready.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      DATA_IO_OE  <= 1'b0; // RULE_20
      DATA_IO_OUT <= '0;
    end
    else if (ce_f || OUTPUT_ENABLE_N || !OUTPUT_DISABLE_N || !we_f)
    begin
      DATA_IO_OE  <= 1'b0; // RULE_17 RULE_18
      DATA_IO_OUT <= '0;
    end
    else
    begin
      // A new address must wait its own access time before data shows.
      DATA_IO_OE  <= (wait_reg == 8'h00) && (bus_snap_reg[AW-1:0] == eff_addr); // RULE_04 RULE_09
      DATA_IO_OUT <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle detector for automatic low power.
  always_ff @(posedge REF_CLK)
  begin
    if (RST || pd)
    begin
      bus_snap_reg <= '0;
      idle_reg     <= 16'h0000;
    end
    else
    begin
      bus_snap_reg <= {CHIP_ENABLE_N, OUTPUT_ENABLE_N, OUTPUT_DISABLE_N,
                       WRITE_ENABLE_N, LATCH_ENABLE_N, eff_addr};
      if (bus_snap_reg != {CHIP_ENABLE_N, OUTPUT_ENABLE_N, OUTPUT_DISABLE_N,
                           WRITE_ENABLE_N, LATCH_ENABLE_N, eff_addr} || !read_on)
        idle_reg <= 16'h0000; // RULE_23
      else if (idle_reg != 16'(IDLE_CYC))
        idle_reg <= idle_reg + 16'h0001;
    end
  end

  // Power state report; data keeps driving in auto low power.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      POWER_STATE <= FBI_PWR_STANDBY;
    else if (pd)
      POWER_STATE <= FBI_PWR_DOWN;
    else if (ce_f && !PE_BUSY)
      POWER_STATE <= FBI_PWR_STANDBY; // RULE_18
    else if (read_on && idle_reg == 16'(IDLE_CYC))
      POWER_STATE <= FBI_PWR_AUTO_LOW; // RULE_19
    else
      POWER_STATE <= FBI_PWR_ACTIVE;
  end

endmodule

// *** tb/fbi_bus_props.sv ***
module fbi_bus_props
  import fbi_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        CHIP_ENABLE_N,
  input wire logic        OUTPUT_ENABLE_N,
  input wire logic        OUTPUT_DISABLE_N,
  input wire logic        WRITE_ENABLE_N,
  input wire logic        RESET_POWERDOWN_N,
  input wire logic [18:0] ADDRESS_IN,
  input wire logic        PE_BUSY,
  input wire logic        BURST_CFG_WE,
  input wire logic [1:0]  READ_STATE,
  input wire logic [31:0] DATA_IO_OUT,
  input wire logic        DATA_IO_OE,
  input wire logic        WR_STROBE,
  input wire logic        SYNC_ALLOWED,
  input wire logic [1:0]  POWER_STATE,
  input wire logic [7:0]  STATUS_OUT
);
  // All checks run on the reference clock; all but chk_reset_async rest during reset.
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  chk_oe_enable:
    assert property (DATA_IO_OE |-> $past(!OUTPUT_ENABLE_N && OUTPUT_DISABLE_N
      && RESET_POWERDOWN_N) && !$past(CHIP_ENABLE_N, 2)) else $error("bus driven while off");
  chk_standby_float:
    assert property ((CHIP_ENABLE_N && !PE_BUSY && RESET_POWERDOWN_N) [*3]
      |-> POWER_STATE == 2'h1 && !DATA_IO_OE) else $error("no standby when deselected");
  chk_pd_float:
    assert property (!RESET_POWERDOWN_N [*2] |-> POWER_STATE == 2'h3 && !DATA_IO_OE)
      else $error("power-down not floating");
  chk_pd_clears:
    assert property (!RESET_POWERDOWN_N [*2] |-> STATUS_OUT == 8'h00 && !WR_STROBE)
      else $error("power-down let a write or status through");
  chk_write_strobes:
    assert property (WR_STROBE |-> $past(!CHIP_ENABLE_N && !WRITE_ENABLE_N, 3))
      else $error("write taken without both strobes low");
  chk_strobe_pulse:
    assert property (WR_STROBE |=> !WR_STROBE) else $error("write strobe too long");
  chk_status_upper:
    assert property (READ_STATE == 2'h2 [*3] ##0 DATA_IO_OE |-> DATA_IO_OUT[31:8] == 24'h0)
      else $error("status read upper lines not low");
  chk_sync_cfg:
    assert property ($rose(SYNC_ALLOWED) |-> $past(BURST_CFG_WE) || $past(BURST_CFG_WE, 2))
      else $error("sync allowed without config write");
  chk_reset_async:
    assert property (disable iff (1'b0) $fell(RST) |-> !SYNC_ALLOWED && !DATA_IO_OE)
      else $error("reset left sync mode on");
  chk_activity_wakes:
    assert property ($changed(ADDRESS_IN) |-> ##2 POWER_STATE != 2'h2)
      else $error("bus activity kept low power");

  // Main scenarios reached.
  cov_write: cover property (WR_STROBE);
  cov_auto_low: cover property (POWER_STATE == 2'h2 && DATA_IO_OE);
  cov_sync: cover property ($rose(SYNC_ALLOWED));
endmodule

bind fbi_flash_bus fbi_bus_props fbi_bus_props_i
(
  .REF_CLK(REF_CLK), .RST(RST), .CHIP_ENABLE_N(CHIP_ENABLE_N),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .OUTPUT_DISABLE_N(OUTPUT_DISABLE_N),
  .WRITE_ENABLE_N(WRITE_ENABLE_N), .RESET_POWERDOWN_N(RESET_POWERDOWN_N),
  .ADDRESS_IN(ADDRESS_IN), .PE_BUSY(PE_BUSY), .BURST_CFG_WE(BURST_CFG_WE),
  .READ_STATE(READ_STATE), .DATA_IO_OUT(DATA_IO_OUT), .DATA_IO_OE(DATA_IO_OE),
  .WR_STROBE(WR_STROBE), .SYNC_ALLOWED(SYNC_ALLOWED), .POWER_STATE(POWER_STATE),
  .STATUS_OUT(STATUS_OUT)
);

// *** tb/fbi_array_model.sv ***
// Flash array behind the interface: every word holds a pattern of its address.
module fbi_array_model
(
  input  wire logic        array_rd,
  input  wire logic [18:0] array_addr,
  output logic      [31:0] array_data
);
  // Same-cycle answer for the registered fetch address; unknown unless fetching.
  assign array_data = array_rd ? {13'h15A3, array_addr} : 32'hxxxx_xxxx;
endmodule

// *** tb/fbi_flash_bus_test.sv ***
module fbi_flash_bus_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] MAKER = 32'h0000_0C3E; // Arbitrary maker code.
  logic        ref_clk = 0, rst = 1, ce_n = 1, oe_n = 1, od_n = 1, we_n = 1, le_n = 0;
  logic        rpn_n = 1, bclk = 0, pe_busy = 0, cfg_we = 0;
  logic [18:0] addr = '0;
  logic [31:0] din = '0, query = 32'h0BAD_F00D;
  logic [7:0]  status = 8'hA5;
  logic [15:0] cfg_in = 16'h0000;
  logic [1:0]  rstate = 2'h0;
  logic [31:0] dout, arr_data, wr_data;
  logic [18:0] arr_addr, wr_addr;
  logic        doe, wr_strobe, sync_ok, ctrl_rst, arr_rd;
  logic [1:0]  pstate;
  logic [7:0]  status_out;
  int          fail_count = 0, checked = 0, strobes = 0, lat;

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // The burst clock wanders freely; the block must not react to it.
  always #3.7 bclk = ~bclk;
  always @(posedge ref_clk) if (wr_strobe === 1'b1) strobes <= strobes + 1;

  fbi_flash_bus #(.IDLE_CYC(8), .MAKER_CODE(MAKER)) fbi_flash_bus_i
  (
    .REF_CLK(ref_clk), .RST(rst), .CHIP_ENABLE_N(ce_n), .OUTPUT_ENABLE_N(oe_n),
    .OUTPUT_DISABLE_N(od_n), .WRITE_ENABLE_N(we_n), .LATCH_ENABLE_N(le_n),
    .RESET_POWERDOWN_N(rpn_n), .BURST_CLK(bclk), .ADDRESS_IN(addr), .DATA_IO_IN(din),
    .DATA_IO_OUT(dout), .DATA_IO_OE(doe), .ARRAY_ADDR(arr_addr), .ARRAY_RD(arr_rd),
    .ARRAY_DATA(arr_data), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_STROBE(wr_strobe),
    .READ_STATE(rstate), .STATUS_IN(status), .QUERY_DATA(query), .PE_BUSY(pe_busy),
    .BURST_CFG_WE(cfg_we), .BURST_CFG_IN(cfg_in), .SYNC_ALLOWED(sync_ok),
    .CTRL_RESET(ctrl_rst), .POWER_STATE(pstate), .STATUS_OUT(status_out)
  );
  fbi_array_model fbi_array_model_i
  (
    .array_rd(arr_rd), .array_addr(arr_addr), .array_data(arr_data)
  );

  function automatic logic [31:0] word(input logic [18:0] a);
    return {13'h15A3, a};
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Waits, bounded, until the expected word is driven; n returns the cycles taken.
  task automatic wait_data(input logic [31:0] exp, output int n);
    n = 0;
    while (!(doe === 1'b1 && dout === exp) && n < 60)
    begin
      cyc(1);
      n++;
    end
    cmp("read data", exp, dout);
    if (n == 60) stop_test();
  endtask
  task automatic rd_start(input logic [18:0] a);
    cyc(1);
    addr = a;
    ce_n = 0;
    oe_n = 0;
  endtask
  task automatic idle();
    cyc(1);
    {ce_n, oe_n, we_n, le_n} = 4'b1110;
    cyc(3);
  endtask
  task automatic reg_rd(input logic [1:0] st, input logic [18:0] a, input logic [31:0] e);
    rstate = st;
    rd_start(a);
    wait_data(e, lat);
    idle();
    rstate = 2'h0;
  endtask
  // A full page: first word slow, neighbours fast, next page slow again.
  task automatic t_page();
    int slow, fast;
    rd_start(19'h0_0100);
    wait_data(word(19'h0_0100), slow);
    for (int i = 1; i < 4; i++)
    begin
      addr = 19'h0_0100 + 19'(i);
      wait_data(word(addr), fast);
      cmp("page hit fast", 32'h1, {31'h0, fast < slow});
    end
    addr = 19'h0_0104;
    wait_data(word(addr), lat);
    cmp("page change slow", 32'h1, {31'h0, lat > fast});
    idle();
  endtask
  task automatic t_disable();
    rd_start(19'h0_0200);
    wait_data(word(addr), lat);
    od_n = 0;
    cyc(2);
    cmp("disable floats", 32'h0, {31'h0, doe});
    od_n = 1;
    wait_data(word(addr), lat);
    oe_n = 1;
    cyc(2);
    cmp("enable off floats", 32'h0, {31'h0, doe});
    oe_n = 0;
    ce_n = 1;
    cyc(4);
    cmp("standby", 32'h1, {30'h0, pstate});
    idle();
  endtask
  task automatic t_latch();
    cyc(1);
    {addr, ce_n, le_n} = {19'h0_0300, 2'b00};
    cyc(2);
    le_n = 1;
    cyc(1);
    addr = 19'h7_7777;
    oe_n = 0;
    wait_data(word(19'h0_0300), lat);
    idle();
  endtask
  task automatic wr(input logic [18:0] a, input logic [31:0] d, input bit ce_up, input bit lat_wr);
    int s;
    s = strobes;
    cyc(1);
    {addr, din, ce_n, oe_n, we_n, le_n} = {a, d, 2'b01, lat_wr, 1'b0};
    if (lat_wr)
    begin
      cyc(2);
      le_n = 1;
      cyc(1);
      addr = ~a;
      we_n = 0;
    end
    cyc(3);
    if (ce_up) ce_n = 1;
    else we_n = 1;
    cyc(5);
    {ce_n, we_n} = 2'b11;
    din = ~d;
    cmp("write count", 32'(s + 1), 32'(strobes));
    cmp("write addr", {13'h0, a}, {13'h0, wr_addr});
    cmp("write data", d, wr_data);
    idle();
  endtask
  // A write strobe pulse far shorter than one cycle must be ignored.
  task automatic t_glitch();
    int s;
    s = strobes;
    cyc(1);
    ce_n = 0;
    #0.5 we_n = 0;
    #1.5 we_n = 1;
    cyc(6);
    cmp("glitch ignored", 32'(s), 32'(strobes));
    idle();
  endtask
  task automatic t_autolow();
    rd_start(19'h0_0400);
    wait_data(word(addr), lat);
    addr = 19'h0_0401;
    cyc(5);
    cmp("awake", 32'h0, {30'h0, pstate});
    cyc(10);
    cmp("auto low", 32'h2, {30'h0, pstate});
    cmp("still driving", word(addr), doe ? dout : 32'h0);
    idle();
  endtask
  task automatic t_pd();
    int s;
    s = strobes;
    cyc(1);
    {rpn_n, ce_n, oe_n} = 3'b000;
    cyc(3);
    cmp("pd state", 32'h3, {30'h0, pstate});
    cmp("pd float", 32'h0, {31'h0, doe});
    cmp("pd status", 32'h0, {24'h0, status_out});
    cmp("pd ctrl reset", 32'h1, {31'h0, ctrl_rst});
    oe_n = 1;
    we_n = 0;
    cyc(3);
    we_n = 1;
    cyc(4);
    cmp("pd blocks write", 32'(s), 32'(strobes));
    {ce_n, rpn_n} = 2'b11;
    cyc(4);
    cmp("async only", 32'h0, {31'h0, sync_ok});
    cfg_in = 16'h1234;
    cfg_we = 1;
    cyc(1);
    cfg_we = 0;
    cyc(2);
    cmp("sync allowed", 32'h1, {31'h0, sync_ok});
    reg_rd(2'h1, 19'h0_0005, 32'h0000_1234);
    reg_rd(2'h2, 19'h0_0033, {24'h0, status});
    rst = 1;
    cyc(2);
    rst = 0;
    cyc(2);
    cmp("reset async", 32'h0, {31'h0, sync_ok});
  endtask

  initial
  begin
    cyc(10);
    rst = 0;
    cyc(2);
    cmp("reset standby", 32'h1, {30'h0, pstate});
    cmp("reset no sync", 32'h0, {31'h0, sync_ok});
    t_page();
    reg_rd(2'h2, 19'h0_0040, {24'h0, status});
    reg_rd(2'h3, 19'h0_0010, query);
    reg_rd(2'h1, 19'h0_0000, MAKER);
    reg_rd(2'h1, 19'h0_0005, 32'h0000_FFFF);
    t_disable();
    t_latch();
    wr(19'h0_1234, 32'hDEAD_0001, 1'b0, 1'b0);
    wr(19'h0_4321, 32'hBEEF_0002, 1'b1, 1'b0);
    wr(19'h0_5A5A, 32'hCAFE_0003, 1'b0, 1'b1);
    t_glitch();
    t_autolow();
    t_pd();
    stop_test();
  end
  initial
  begin
    #200us;
    fail_count++;
    stop_test();
  end
endmodule
